// *** logic/squib_cfg_pkg.sv ***
// Shared constants and types for the configuration command link.
// What this block does
// - Top bits zero; D10 picks frame variant.
// - D13 makes each 16-bit word except the 0x0000 power-on answer odd parity.
// - D12 zero reads and ignores D11 and D9..D0.
// - Current write updates all channels, ignores low byte.
// - Reset-select write uses low byte, ignores D9:D8.
// - Current level codes 00..11, reset 00.
// - Current response echoes bits, stored level, 0x02.
// - Powered-up flag zero first, then one.
// - Soft reset needs 0xAA then 0x55 consecutively.
// - Host resends whole pattern after interruption.
// - Soft reset clears level, latch, pattern and powered-up state; response is 0x2003.
// - D0 reports a completed soft reset.
// - After valid pattern the next answer is 0x2003.
// - Latch command uses D9:D8; response echoes them.
// - Latch codes 0/128/256/512 ms, reset 00.
// - First pattern word answers 0x1X02.
// - Parity/unknown gives 0xD000; bad length 0xD003.
// - Response goes out in the next frame.
package squib_cfg_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int HALF_CYCLES = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] WORD_BITS_5 = 5'h10;
  localparam int BIT_MODE_HI = 15;
  localparam int BIT_MODE_LO = 14;
  localparam int BIT_PARITY = 13;
  localparam int BIT_WRITE = 12;
  localparam int BIT_RESET_SEL = 11;
  localparam int BIT_VARIANT = 10;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [1:0] LATCH_RESET = 2'h0;
  localparam logic [7:0] RESET_WORD_A = 8'hAA;
  localparam logic [7:0] RESET_WORD_B = 8'h55;
  localparam logic [15:0] RESP_POR = 16'h0000;
  localparam logic [15:0] RESP_BAD_FRAME = 16'hD000;
  localparam logic [15:0] RESP_BAD_LENGTH = 16'hD003;
  localparam logic [15:0] RESP_RESET_DONE = 16'h2003;
  localparam logic [15:0] RESP_RESET_FIRST = 16'h1802;
  localparam logic [7:0] MODE1_LOW_BYTE = 8'h02;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_RESP = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_MASK = 8'h0C;
  localparam int STATUS_DONE = 0;
  localparam int RESP_BUSY = 16;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_LEAD = 3'b001,
    LINK_SHIFT = 3'b011,
    LINK_TRAIL = 3'b010,
    LINK_GAP = 3'b110
  } link_state_t;

  // Odd parity: D13 is chosen so the whole word holds an odd count of ones.
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] t;
    t = w;
    t[BIT_PARITY] = 1'b0;
    t[BIT_PARITY] = ~(^t);
    return t;
  endfunction : with_parity
endpackage : squib_cfg_pkg

// *** logic/squib_cfg_link_if.sv ***
// Four-wire serial link between the controller and the configuration handler.
interface squib_cfg_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : squib_cfg_link_if

// *** logic/squib_cfg_device.sv ***
// Device end: decodes configuration frames and builds the next response.
module squib_cfg_device (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  squib_cfg_link_if.device link,
  output logic [1:0] current_level_bits,
  output logic [1:0] latch_time,
  output logic soft_reset_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] mosi_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
    end else if (ce) begin
      sclk_s_q <= {sclk_s_q[1:0], link.sclk};
      cs_s_q <= {cs_s_q[1:0], link.cs_n};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
    end
  end
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire cs_start = ~cs_s_q[1] & cs_s_q[2];
  wire cs_end = cs_s_q[1] & ~cs_s_q[2];
  wire in_frame = ~cs_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [4:0] count_q;
  logic [15:0] resp_q;
  logic [1:0] level_q;
  logic [1:0] latch_q;
  logic pending_q;
  logic powered_q;
  logic miso_q;
  logic reset_pulse_q;

  // Frame decode, all continuous.
  wire len_ok = count_q == squib_cfg_pkg::WORD_BITS_5;
  wire parity_ok = ^rx_q;
  wire config_cmd = ~rx_q[squib_cfg_pkg::BIT_MODE_HI] & ~rx_q[squib_cfg_pkg::BIT_MODE_LO];
  wire variant = rx_q[squib_cfg_pkg::BIT_VARIANT];
  wire is_write = rx_q[squib_cfg_pkg::BIT_WRITE];
  wire reset_sel = rx_q[squib_cfg_pkg::BIT_RESET_SEL];
  wire [7:0] low_byte = rx_q[7:0];
  wire level_write = config_cmd & ~variant & is_write & ~reset_sel;
  wire reset_frame = config_cmd & ~variant & is_write & reset_sel;
  wire first_word = reset_frame & (low_byte == squib_cfg_pkg::RESET_WORD_A);
  wire second_word = reset_frame & pending_q & (low_byte == squib_cfg_pkg::RESET_WORD_B);
  wire latch_write = config_cmd & variant & is_write;
  wire [1:0] level_next = level_write ? rx_q[9:8] : level_q;
  wire echo_sel = is_write & reset_sel;
  wire [15:0] mode1_resp = squib_cfg_pkg::with_parity(
    {3'b000, is_write, echo_sel, 1'b0, level_next, 6'h00, powered_q, 1'b0});
  // D1 carries the powered-up flag here too, so a pattern word sent first after reset reads zero.
  wire [15:0] first_resp = squib_cfg_pkg::with_parity(
    {squib_cfg_pkg::RESP_RESET_FIRST[15:2], powered_q, squib_cfg_pkg::RESP_RESET_FIRST[0]} |
    {6'h00, level_q, 8'h00});
  wire [1:0] latch_next = latch_write ? rx_q[9:8] : latch_q;
  wire [15:0] mode2_resp = squib_cfg_pkg::with_parity(
    {3'b000, is_write, 2'b01, latch_next, 8'h00});
  wire [15:0] good_resp = variant ? mode2_resp : (first_word ? first_resp : mode1_resp);
  wire [15:0] frame_resp = !len_ok ? squib_cfg_pkg::RESP_BAD_LENGTH :
                           (!parity_ok || !config_cmd) ? squib_cfg_pkg::RESP_BAD_FRAME :
                           second_word ? squib_cfg_pkg::RESP_RESET_DONE : good_resp;
  wire frame_good = len_ok & parity_ok & config_cmd;
  wire do_reset = cs_end & frame_good & second_word;

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifting: sample on the rising link edge, change output on falling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      count_q <= 5'h00;
      miso_q <= 1'b0;
    end else if (ce) begin
      if (cs_start) begin
        tx_q <= resp_q;
        miso_q <= resp_q[15];
        count_q <= 5'h00;
      end else if (in_frame && sclk_rise) begin
        rx_q <= {rx_q[14:0], mosi_s_q[1]};
        if (count_q != 5'h1F)
          count_q <= count_q + 5'h01;
      end else if (in_frame && sclk_fall) begin
        tx_q <= {tx_q[14:0], 1'b0};
        miso_q <= tx_q[14];
      end
    end
  end

  // A soft reset clears level, latch, pattern and powered-up state, not the shift registers or the response it must report.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= squib_cfg_pkg::RESP_POR;
      level_q <= squib_cfg_pkg::LEVEL_RESET;
      latch_q <= squib_cfg_pkg::LATCH_RESET;
      pending_q <= 1'b0;
      powered_q <= 1'b0;
      reset_pulse_q <= 1'b0;
    end else if (ce) begin
      reset_pulse_q <= do_reset;
      if (cs_end) begin
        resp_q <= frame_resp;
        if (do_reset) begin
          level_q <= squib_cfg_pkg::LEVEL_RESET;
          latch_q <= squib_cfg_pkg::LATCH_RESET;
          pending_q <= 1'b0;
          powered_q <= 1'b0;
        end else begin
          powered_q <= 1'b1;
          pending_q <= frame_good & first_word;
          if (frame_good) begin
            level_q <= level_next;
            latch_q <= latch_next;
          end
        end
      end
    end
  end

  assign link.miso = miso_q;
  assign current_level_bits = level_q;
  assign latch_time = latch_q;
  assign soft_reset_pulse = reset_pulse_q;
endmodule : squib_cfg_device

// *** logic/squib_cfg_host.sv ***
// Host end: APB-programmed controller that sends one frame per command write made while the link is idle.
//
// Added by the designer: register access over APB and the placing of the registers.
module squib_cfg_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  squib_cfg_link_if.host link
);
  ////////////////////////////////////////////////////////////////////////////
  squib_cfg_pkg::link_state_t state_q;
  logic [3:0] div_q;
  logic [4:0] bits_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [15:0] resp_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic [1:0] miso_s_q;
  logic done_q;
  logic mask_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire setup = psel & ~penable;
  wire access_done = psel & penable & pready_q;
  wire hit_cmd = paddr == squib_cfg_pkg::APB_CMD;
  wire hit_resp = paddr == squib_cfg_pkg::APB_RESP;
  wire hit_status = paddr == squib_cfg_pkg::APB_STATUS;
  wire hit_mask = paddr == squib_cfg_pkg::APB_MASK;
  wire mapped = hit_cmd | hit_resp | hit_status | hit_mask;
  wire busy = state_q != squib_cfg_pkg::LINK_IDLE;
  // Software must resend the whole reset pattern if anything intervenes.
  wire start = access_done & pwrite & hit_cmd & ~busy;
  wire clear_done = access_done & pwrite & hit_status & pwdata[squib_cfg_pkg::STATUS_DONE];
  wire [15:0] start_word = squib_cfg_pkg::with_parity(pwdata[15:0]);
  wire half_tick = div_q == 4'(squib_cfg_pkg::HALF_CYCLES - 1);
  wire frame_done = (state_q == squib_cfg_pkg::LINK_TRAIL) & half_tick;
  wire [31:0] read_mux = hit_resp ? {15'h0000, busy, resp_q} :
                         hit_status ? {31'h0000_0000, done_q} :
                         hit_mask ? {31'h0000_0000, mask_q} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Registered answers give a zero-wait access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mask_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= read_mux;
      if (access_done && pwrite && hit_mask)
        mask_q <= pwdata[0];
      // A completion in the clearing cycle wins.
      done_q <= frame_done | (done_q & ~clear_done);
      irq_q <= (frame_done | (done_q & ~clear_done)) & mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link engine: the link clock is divided from pclk, mode 0 framing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_s_q <= 2'h0;
    end else if (ce) begin
      miso_s_q <= {miso_s_q[0], link.miso};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= squib_cfg_pkg::LINK_IDLE;
      div_q <= 4'h0;
      bits_q <= 5'h00;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      resp_q <= 16'h0000;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
    end else if (ce) begin
      div_q <= (busy && !half_tick) ? div_q + 4'h1 : 4'h0;
      unique case (state_q)
        squib_cfg_pkg::LINK_IDLE: begin
          if (start) begin
            tx_q <= start_word;
            mosi_q <= start_word[15];
            cs_n_q <= 1'b0;
            bits_q <= 5'h00;
            state_q <= squib_cfg_pkg::LINK_LEAD;
          end
        end
        squib_cfg_pkg::LINK_LEAD: begin
          if (half_tick)
            state_q <= squib_cfg_pkg::LINK_SHIFT;
        end
        squib_cfg_pkg::LINK_SHIFT: begin
          if (half_tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rx_q <= {rx_q[14:0], miso_s_q[1]};
              bits_q <= bits_q + 5'h01;
            end else if (bits_q == squib_cfg_pkg::WORD_BITS_5) begin
              state_q <= squib_cfg_pkg::LINK_TRAIL;
            end else begin
              tx_q <= {tx_q[14:0], 1'b0};
              mosi_q <= tx_q[14];
            end
          end
        end
        squib_cfg_pkg::LINK_TRAIL: begin
          if (half_tick) begin
            cs_n_q <= 1'b1;
            resp_q <= rx_q;
            state_q <= squib_cfg_pkg::LINK_GAP;
          end
        end
        squib_cfg_pkg::LINK_GAP: begin
          if (half_tick)
            state_q <= squib_cfg_pkg::LINK_IDLE;
        end
        default: state_q <= squib_cfg_pkg::LINK_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
endmodule : squib_cfg_host

// *** bench/squib_cfg_link_properties.sv ***
// Checker of the serial link timing between the two ends.
module squib_cfg_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  // Counts link clock rises inside a frame; saturation is not needed at 16.
  logic [4:0] cnt_q;
  logic sclk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cnt_q <= cs_n ? 5'h00 : cnt_q + 5'(sclk & ~sclk_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock moved outside a frame");
  chk_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase wrong");
  chk_sclk_low_half: assert property (($fell(sclk) && cnt_q < 5'h10) |-> !sclk [*8] ##1 sclk)
    else $error("link clock low phase wrong");
  chk_frame_bits: assert property ($rose(cs_n) |-> cnt_q == 5'h10)
    else $error("frame did not hold sixteen bits");
  chk_trail_time: assert property (($fell(sclk) && cnt_q == 5'h10) |-> !cs_n [*7] ##[1:2] cs_n)
    else $error("frame end late or early");
  chk_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  chk_lead_time: assert property ($fell(cs_n) |-> !sclk [*8] ##1 !sclk [*7] ##[1:3] sclk)
    else $error("lead time wrong");
  chk_mosi_hold: assert property ((sclk && $past(sclk)) |-> $stable(mosi))
    else $error("host data moved while clock high");
  chk_miso_hold: assert property ((sclk && $past(sclk)) |-> $stable(miso))
    else $error("device data moved while clock high");
endmodule : squib_cfg_link_properties

// *** bench/test_spi_config_command_handler.sv ***
// Self-checking bench for both ends of the configuration command link.
module test_spi_config_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, irq, pulse, aa, pu;
  logic [1:0] cl_o, lat_o, cl, lat;
  logic [15:0] lf = 16'h0031, pend;
  logic [15:0] cmds [29] = '{16'h0C00, 16'h11AA, 16'h1355, 16'h1200, 16'h1000, 16'h1500,
    16'h1600, 16'h1700, 16'h1400, 16'h0400, 16'h4000, 16'h8000, 16'hC0FF, 16'h1B00, 16'h18AA,
    16'h0000, 16'h1855, 16'h1B55, 16'h1301, 16'h1700, 16'h18AA, 16'h18AA, 16'h1B55, 16'h0000,
    16'h0000, 16'h18AA, 16'hC000, 16'h1855, 16'h2000};
  int fail_count = 0, tests_run = 0, pulses = 0, exp_pulses = 0;
  squib_cfg_link_if link ();
  squib_cfg_host squib_cfg_host_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  squib_cfg_device squib_cfg_device_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(link), .current_level_bits(cl_o), .latch_time(lat_o), .soft_reset_pulse(pulse));
  squib_cfg_link_properties squib_cfg_link_properties_inst (.pclk(pclk), .presetn(presetn),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (pulse === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic logic [15:0] par(input logic [15:0] w);
    w[13] = ~^{w[15:14], w[12:0]};
    return w;
  endfunction : par
  // Expected answer to a frame; it also steps the expected device state.
  function automatic logic [15:0] model(input logic [15:0] c);
    logic [15:0] r;
    logic a, p;
    {a, p, aa, pu, r} = {aa, pu, 2'b01, 16'hD000};
    if (c[15:14] != 2'b00) return r;
    if (c[10]) begin
      if (c[12]) lat = c[9:8];
      r = par({3'b000, c[12], 2'b01, lat, 8'h00});
    end else begin
      if (c[12] && !c[11]) cl = c[9:8];
      aa = c[12] && c[11] && c[7:0] == 8'hAA;
      r = par({3'b000, c[12], c[12] & c[11], 1'b0, cl, 6'h00, p, 1'b0});
      if (a && c[12] && c[11] && c[7:0] == 8'h55) begin
        {cl, lat, pu, r} = {4'h0, 1'b0, 16'h2003};
        exp_pulses++;
      end
    end
    return r;
  endfunction : model
  task automatic complete_run(input logic hung);
    if (hung) fail_count++;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      if (++n > 20) complete_run(1'b1);
    end while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic frame(input logic [15:0] c);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, 8'h00, {16'h0000, c}, r, e);
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0000_0000, r, e);
      if (++n > 200) complete_run(1'b1);
    end while (r[16] !== 1'b0);
    chk({16'h0000, r[15:0]}, {16'h0000, pend});
    pend = model(c);
    chk({cl_o, lat_o}, {cl, lat});
  endtask : frame
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    logic [15:0] c;
    {pend, cl, lat, aa, pu} = {16'h0000, 4'h0, 2'b00};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_0001, r, e);
    frame(16'h0000);
    chk(irq, 1'b1);
    apb(1'b1, 8'h08, 32'h0000_0001, r, e);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, 8'h0C, 32'h0000_0000, r, e);
    frame(16'h0000);
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    chk({r[0], irq}, 2'b10);
    $display("test status and mask done");
    foreach (cmds[i]) frame(cmds[i]);
    $display("test corner frames done");
    repeat (40) begin
      lf = nxt(lf);
      c = lf;
      if (lf[3:0] != 4'h0) c[15:14] = 2'b00;
      if (c[10]) c[11:0] = {2'b01, c[9:8], 8'h00};
      frame(c);
    end
    frame(16'h0000);
    chk(pulses, exp_pulses);
    $display("test random frames done");
    complete_run(1'b0);
  end
endmodule : test_spi_config_command_handler
